// File: verilog/sfb_cfg.svh
// Constants of the serial flash buffer and page command block.
// Assumes a 10 MHz system clock; times are in microseconds.
`ifndef SFB_CFG_SVH
`define SFB_CFG_SVH
`define SFB_OP_CONT_READ  8'he8
`define SFB_OP_PAGE_READ  8'hd2
`define SFB_OP_BUF1_FAST  8'hd4
`define SFB_OP_BUF1_SLOW  8'hd1
`define SFB_OP_BUF2_FAST  8'hd6
`define SFB_OP_BUF2_SLOW  8'hd3
`define SFB_OP_BUF1_WRITE 8'h84
`define SFB_OP_BUF2_WRITE 8'h87
`define SFB_OP_BUF1_PGE   8'h83
`define SFB_OP_BUF2_PGE   8'h86
`define SFB_OP_BUF1_PG    8'h88
`define SFB_OP_BUF2_PG    8'h89
`define SFB_BUF_BYTES     528
`define SFB_LAST_528      10'h20f
`define SFB_LAST_512      10'h1ff
`define SFB_LAST_PAGE     13'h1fff
`define SFB_ADDR_LAST     2'h2
`define SFB_DUMMY_MAIN    2'h3
`define SFB_DUMMY_BUF     2'h0
`define SFB_FIFO_DEPTH    16
`define SFB_CLK_MHZ       10
`define SFB_EP_TIME_US    10000
`define SFB_P_TIME_US     5000
`endif

// File: verilog/sfb_pkg.sv
// Types shared by the serial flash buffer and page command block.
// Assumes sfb_cfg.svh is on the include path.
package sfb_pkg;
    typedef enum logic [1:0] {ST_IDLE_X} sfb_unused_type;
    typedef enum {ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_ARMED,
                  ST_IGNORE} sfb_state_type;
    typedef enum {CMD_CONT, CMD_PAGE, CMD_BUFRD, CMD_BUFWR, CMD_PROG} sfb_cmd_type;
    typedef struct packed {
        logic       sel;
        logic [9:0] off;
        logic [7:0] data;
    } sfb_wr_type;
    typedef struct packed {
        logic [12:0] page_number_bits;
        logic [9:0]  byte_in_page_bits;
    } sfb_arr_rd_type;
    typedef struct packed {
        logic        erase;
        logic        en;
        logic [12:0] page;
        logic [9:0]  idx;
        logic [7:0]  data;
    } sfb_arr_wr_type;
endpackage

// File: verilog/sfb_sync.sv
// Two-flop synchroniser for pin levels entering the system clock domain.
// Assumes inputs are asynchronous levels; no logic reads the first stage.
`timescale 1ns/1ps
`default_nettype none
module sfb_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    // Levels
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= '1;
            q_out  <= '1;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule // sfb_sync
`default_nettype wire

// File: verilog/sfb_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock; full and empty derive from wrapped pointers.
`timescale 1ns/1ps
`default_nettype none
module sfb_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;

    assign in_ready_out  = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
    assign out_valid_out = wp_q != rp_q;
    assign out_data_out  = mem[rp_q[AW-1:0]];

    always_ff @(posedge sys_clk_in) begin
        if (in_valid_in && in_ready_out) begin
            mem[wp_q[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (in_valid_in && in_ready_out) begin
                wp_q <= wp_q + 1'b1;
            end
            if (out_valid_out && out_ready_in) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule // sfb_fifo
`default_nettype wire

// File: verilog/sfb_top.sv
// Serial flash command logic: reads, buffer write, buffer to page program.
// Assumes the main array sits outside on the arr ports, read data valid
// one cycle after the address, and serial pins asynchronous to sys_clk_in.
// Function
// - continuous read wraps array end to page zero
// - chip select rise ends read, output off
// - continuous read leaves both buffers untouched
// - 528 mode page read: D2H, 13+10, 4 dummies
// - 512 mode page read: 13 page, 9 byte
// - after dummies, one bit per clock out
// - page read wraps within same page
// - page read any page, buffers unchanged
// - buffer read D4H/D1H first, D6H/D3H second
// - 528 mode buffer address: 14 ignored, 10 offset
// - 512 mode buffer address: 15 ignored, 9 offset
// - buffer read takes exactly one dummy byte
// - buffer read wraps to offset zero
// - buffer write 84H/87H, read address layout
// - write data fills successive positions, wrapping
// - buffer write runs until select rises
// - erase program 83H/86H, page address layout
// - select rise erases page, programs, busy
// - program 88H/89H, busy until done
// - command opens on select fall, 8-bit opcode
// - everything shifted most significant bit first
`timescale 1ns/1ps
`default_nettype none
`include "sfb_cfg.svh"
module sfb_top #(
    parameter int unsigned EP_CYCLES = `SFB_EP_TIME_US * `SFB_CLK_MHZ,
    parameter int unsigned P_CYCLES  = `SFB_P_TIME_US * `SFB_CLK_MHZ
) (
    // Clock and reset
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_n_in,
    // Serial link
    input  wire logic                    cs_n_in,
    input  wire logic                    sck_in,
    input  wire logic                    si_in,
    output logic                         so_out,
    output logic                         so_oe_out,
    // Configuration and status
    input  wire logic                    page512_in,
    output logic                         ready_out,
    output logic                         wr_ready_out,
    // Main array port
    output var sfb_pkg::sfb_arr_rd_type  arr_rd_out,
    input  wire logic [7:0]              arr_rd_data_in,
    output var sfb_pkg::sfb_arr_wr_type  arr_wr_out
);
    import sfb_pkg::*;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    logic [3:0]    pin_s;
    logic          cs_s, sck_s, si_s, p512_s;
    logic          sck_prev_q, cs_prev_q;
    logic          sck_rise, sck_fall, cs_rise, cs_fall;
    sfb_state_type state_q;
    sfb_cmd_type   cmd_q;
    logic          bsel_q, erase_q, p512_q;
    logic [2:0]    bit_q;
    logic [1:0]    cnt_q;
    logic [6:0]    sh_q;
    logic [15:0]   addr_q;
    logic [7:0]    byte_in;
    logic          byte_done, addr_done, load, push, busy_any;
    logic [23:0]   full_addr;
    logic [12:0]   page_dec;
    logic [9:0]    off_dec, last;
    logic [9:0]    boff_q, wr_off_q;
    logic [7:0]    bmem [2][`SFB_BUF_BYTES];
    logic [7:0]    buf_rd_q, src;
    logic [6:0]    so_sh_q;
    logic          fifo_out_valid, copy_q, drain;
    sfb_wr_type    fifo_out;
    logic          pend_q, busy_q, start;
    logic          prog_sel_q, prog_erase_q;
    logic [12:0]   prog_page_q;
    logic [9:0]    prog_last_q, cidx_q;
    logic [19:0]   timer_q;

    sfb_sync #(.WIDTH(4)) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .d_in       ({cs_n_in, sck_in, si_in, page512_in}),
        .q_out      (pin_s)
    );
    assign {cs_s, sck_s, si_s, p512_s} = pin_s;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sck_prev_q <= 1'b1;
            cs_prev_q  <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q  <= cs_s;
        end
    end

    assign sck_rise  = sck_s && !sck_prev_q && !cs_s;
    assign sck_fall  = !sck_s && sck_prev_q && !cs_s;
    assign cs_rise   = cs_s && !cs_prev_q;
    assign cs_fall   = !cs_s && cs_prev_q;
    assign byte_in   = {sh_q, si_s};
    assign byte_done = sck_rise && (bit_q == 3'h7);
    assign addr_done = byte_done && (state_q == ST_ADDR) && (cnt_q == `SFB_ADDR_LAST);
    assign full_addr = {addr_q, byte_in};
    assign last      = p512_q ? `SFB_LAST_512 : `SFB_LAST_528;
    assign busy_any  = busy_q || pend_q;
    assign page_dec  = p512_q ? full_addr[21:9] : full_addr[22:10];
    assign off_dec   = p512_q ? {1'b0, full_addr[8:0]} : full_addr[9:0];

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_q <= 3'h0;
            sh_q  <= 7'h00;
        end else if (cs_s) begin
            bit_q <= 3'h0;
        end else if (sck_rise) begin
            bit_q <= bit_q + 3'h1;
            sh_q  <= {sh_q[5:0], si_s};
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            cmd_q   <= CMD_CONT;
            bsel_q  <= 1'b0;
            erase_q <= 1'b0;
            p512_q  <= 1'b0;
            cnt_q   <= 2'h0;
            addr_q  <= 16'h0000;
        end else if (cs_s) begin
            state_q <= ST_IDLE;
        end else if (cs_fall) begin
            state_q <= ST_OPCODE;
            p512_q  <= p512_s;
            cnt_q   <= 2'h0;
        end else if (byte_done) begin
            unique case (state_q)
                ST_OPCODE: begin
                    state_q <= ST_ADDR;
                    cnt_q   <= 2'h0;
                    unique case (byte_in)
                        `SFB_OP_CONT_READ:  cmd_q <= CMD_CONT;
                        `SFB_OP_PAGE_READ:  cmd_q <= CMD_PAGE;
                        `SFB_OP_BUF1_FAST, `SFB_OP_BUF1_SLOW,
                        `SFB_OP_BUF2_FAST, `SFB_OP_BUF2_SLOW: cmd_q <= CMD_BUFRD;
                        `SFB_OP_BUF1_WRITE, `SFB_OP_BUF2_WRITE: cmd_q <= CMD_BUFWR;
                        `SFB_OP_BUF1_PGE, `SFB_OP_BUF2_PGE,
                        `SFB_OP_BUF1_PG, `SFB_OP_BUF2_PG: cmd_q <= CMD_PROG;
                        default: state_q <= ST_IGNORE;
                    endcase
                    bsel_q  <= (byte_in == `SFB_OP_BUF2_FAST) || (byte_in == `SFB_OP_BUF2_SLOW)
                            || (byte_in == `SFB_OP_BUF2_WRITE) || (byte_in == `SFB_OP_BUF2_PGE)
                            || (byte_in == `SFB_OP_BUF2_PG);
                    erase_q <= (byte_in == `SFB_OP_BUF1_PGE) || (byte_in == `SFB_OP_BUF2_PGE);
                    // Array commands are ignored while a program runs or is pending
                    if (busy_any && (byte_in == `SFB_OP_CONT_READ
                        || byte_in == `SFB_OP_PAGE_READ || byte_in[7:4] == 4'h8
                        && byte_in != `SFB_OP_BUF1_WRITE && byte_in != `SFB_OP_BUF2_WRITE)) begin
                        state_q <= ST_IGNORE;
                    end
                end
                ST_ADDR: begin
                    addr_q <= {addr_q[7:0], byte_in};
                    cnt_q  <= cnt_q + 2'h1;
                    if (cnt_q == `SFB_ADDR_LAST) begin
                        cnt_q <= 2'h0;
                        unique case (cmd_q)
                            CMD_PROG:  state_q <= ST_ARMED;
                            CMD_BUFWR: state_q <= ST_WDATA;
                            CMD_CONT, CMD_PAGE, CMD_BUFRD: state_q <= ST_DUMMY;
                        endcase
                    end
                end
                ST_DUMMY: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (cnt_q == ((cmd_q == CMD_BUFRD) ? `SFB_DUMMY_BUF : `SFB_DUMMY_MAIN)) begin
                        state_q <= ST_RDATA;
                    end
                end
                ST_IDLE, ST_RDATA, ST_WDATA, ST_ARMED, ST_IGNORE: ;
            endcase
        end
    end

    assign load = sck_fall && (state_q == ST_RDATA) && (bit_q == 3'h0);
    assign push = byte_done && (state_q == ST_WDATA);

    // Address counters for reads and writes
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arr_rd_out  <= '0;
            boff_q      <= 10'h000;
            wr_off_q    <= 10'h000;
            prog_page_q <= 13'h0000;
        end else if (addr_done) begin
            arr_rd_out  <= '{page_dec, off_dec};
            boff_q      <= off_dec;
            wr_off_q    <= off_dec;
            prog_page_q <= (cmd_q == CMD_PROG) ? page_dec : prog_page_q;
        end else if (load && cmd_q == CMD_BUFRD) begin
            boff_q <= (boff_q == last) ? 10'h000 : boff_q + 10'h001;
        end else if (load) begin
            if (arr_rd_out.byte_in_page_bits == last) begin
                arr_rd_out.byte_in_page_bits <= 10'h000;
                if (cmd_q == CMD_CONT) begin
                    arr_rd_out.page_number_bits <= arr_rd_out.page_number_bits + 13'h0001;
                end
                // page read stays on its page
            end else begin
                arr_rd_out.byte_in_page_bits <= arr_rd_out.byte_in_page_bits + 10'h001;
            end
        end else if (push) begin
            wr_off_q <= (wr_off_q == last) ? 10'h000 : wr_off_q + 10'h001;
        end
    end

    assign src = (cmd_q == CMD_BUFRD) ? buf_rd_q : arr_rd_data_in;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            so_out    <= 1'b0;
            so_sh_q   <= 7'h00;
            so_oe_out <= 1'b0;
        end else begin
            so_oe_out <= !cs_s && (state_q == ST_RDATA);
            if (load) begin
                so_out  <= src[7];
                so_sh_q <= src[6:0];
            end else if (sck_fall && state_q == ST_RDATA) begin
                so_out  <= so_sh_q[6];
                so_sh_q <= {so_sh_q[5:0], 1'b0};
            end
        end
    end

    sfb_fifo #(.WIDTH($bits(sfb_wr_type)), .DEPTH(`SFB_FIFO_DEPTH)) u_fifo (
        .sys_clk_in    (sys_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (push),
        .in_ready_out  (wr_ready_out),
        .in_data_in    ({bsel_q, wr_off_q, byte_in}),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (!copy_q),
        .out_data_out  (fifo_out)
    );
    assign drain = fifo_out_valid && !copy_q;

    // Buffer storage: FIFO drain writes, reads for output and copy
    always_ff @(posedge sys_clk_in) begin
        if (drain) begin
            bmem[fifo_out.sel][fifo_out.off] <= fifo_out.data;
        end
        buf_rd_q <= bmem[bsel_q][boff_q];
    end
    assign start = pend_q && !fifo_out_valid && !busy_q;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q       <= 1'b0;
            busy_q       <= 1'b0;
            copy_q       <= 1'b0;
            cidx_q       <= 10'h000;
            timer_q      <= 20'h00000;
            prog_sel_q   <= 1'b0;
            prog_erase_q <= 1'b0;
            prog_last_q  <= 10'h000;
        end else begin
            if (cs_rise && state_q == ST_ARMED) begin
                pend_q       <= 1'b1;
                prog_sel_q   <= bsel_q;
                prog_erase_q <= erase_q;
                prog_last_q  <= last;
            end else if (start) begin
                pend_q  <= 1'b0;
                busy_q  <= 1'b1;
                copy_q  <= 1'b1;
                cidx_q  <= 10'h000;
                timer_q <= prog_erase_q ? 20'(EP_CYCLES - 1) : 20'(P_CYCLES - 1);
            end
            if (busy_q) begin
                timer_q <= timer_q - 20'h00001;
                if (timer_q == 20'h00000) begin
                    busy_q <= 1'b0;
                end
                if (copy_q) begin
                    copy_q <= cidx_q != prog_last_q;
                    cidx_q <= cidx_q + 10'h001;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arr_wr_out <= '0;
            ready_out  <= 1'b1;
        end else begin
            ready_out        <= !busy_any;
            arr_wr_out.erase <= start && prog_erase_q;
            arr_wr_out.en    <= copy_q && busy_q;
            arr_wr_out.page  <= prog_page_q;
            arr_wr_out.idx   <= cidx_q;
            arr_wr_out.data  <= copy_q ? bmem[prog_sel_q][cidx_q] : 8'h00;
        end
    end

    property p_cs_rise_hiz;
        cs_rise |=> !so_oe_out;
    endproperty
    a_cs_rise_hiz: assert property (p_cs_rise_hiz) else $error("output on after cs rise");
    property p_page_wrap;
        load && cmd_q == CMD_PAGE && arr_rd_out.byte_in_page_bits == last
            |=> arr_rd_out.byte_in_page_bits == 10'h000 && $stable(arr_rd_out.page_number_bits);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page read left its page");
    property p_cont_wrap;
        load && cmd_q == CMD_CONT && arr_rd_out.byte_in_page_bits == last
            && arr_rd_out.page_number_bits == `SFB_LAST_PAGE |=> arr_rd_out == '0;
    endproperty
    a_cont_wrap: assert property (p_cont_wrap) else $error("array end did not wrap");
    property p_buf_wrap;
        load && cmd_q == CMD_BUFRD && boff_q == last |=> boff_q == 10'h000;
    endproperty
    a_buf_wrap: assert property (p_buf_wrap) else $error("buffer read did not wrap");
    property p_wr_wrap;
        push && wr_off_q == last |=> wr_off_q == 10'h000;
    endproperty
    a_wr_wrap: assert property (p_wr_wrap) else $error("buffer write did not wrap");
    property p_no_push_main;
        (cmd_q == CMD_CONT || cmd_q == CMD_PAGE) && state_q == ST_RDATA |-> !push && !drain;
    endproperty
    a_no_push_main: assert property (p_no_push_main) else $error("array read hit buffer");
    property p_prog_busy;
        start |=> busy_q && !ready_out ##1 arr_wr_out.en && arr_wr_out.idx == 10'h000;
    endproperty
    a_prog_busy: assert property (p_prog_busy) else $error("program did not start");
    property p_so_bit;
        load |=> so_out == $past(src[7]) && so_oe_out;
    endproperty
    a_so_bit: assert property (p_so_bit) else $error("wrong first output bit");
endmodule // sfb_top
`default_nettype wire

// File: verif/sfb_host_model.sv
// Host serial controller model: select, clock and data towards the block.
// Assumes the bench system clock paces it; serial clock idles low.
`timescale 1ns/1ps
`default_nettype none
module sfb_host_model (
    // Pacing clock
    input  wire logic sys_clk_in,
    // Serial link
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      si_out,
    input  wire logic so_in,
    input  wire logic so_oe_in
);
    logic [7:0] wbuf [16];
    logic [7:0] rbuf [16];
    logic       oe_seen;

    initial begin
        cs_n_out = 1'b1;
        sck_out  = 1'b0;
        si_out   = 1'b0;
        oe_seen  = 1'b0;
    end

    task automatic half();
        repeat (4) @(negedge sys_clk_in);
    endtask

    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_out = tx[i];
            half();
            sck_out = 1'b1;
            half();
            // Undriven line reads as the inverse of its last level
            rx[i] = so_oe_in ? so_in : ~so_in;
            oe_seen = so_oe_in;
            sck_out = 1'b0;
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [23:0] addr,
                       input int ndum, input int nw, input int nr);
        logic [7:0] junk;
        cs_n_out = 1'b0;
        half();
        xbyte(op, junk);
        for (int i = 2; i >= 0; i--) xbyte(addr[i*8 +: 8], junk);
        repeat (ndum) xbyte(8'h00, junk);
        for (int i = 0; i < nw; i++) xbyte(wbuf[i], junk);
        for (int i = 0; i < nr; i++) xbyte(8'h00, rbuf[i]);
        half();
        cs_n_out = 1'b1;
        si_out = ~si_out;
        repeat (3) half();
    endtask
endmodule // sfb_host_model
`default_nettype wire

// File: verif/tb_top.sv
// Testbench of the serial flash command block with a behavioural array.
// Assumes the host model paces the link; programs shortened to 700 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sfb_pkg::*;
    logic           sys_clk_in, rst_n_in, cs_n_in, sck_in, si_in, so_out, so_oe_out;
    logic           page512_in, ready_out, wr_ready_out, er_seen;
    sfb_arr_rd_type arr_rd_out;
    sfb_arr_wr_type arr_wr_out;
    logic [7:0]     arr_rd_data_in, wr_first;
    logic [12:0]    er_page, wr_page;
    logic [9:0]     wr_idx;
    int             num_errors, comparisons, cycles, wr_cnt;

    sfb_top #(.EP_CYCLES(700), .P_CYCLES(700)) DUT (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in),
        .sck_in(sck_in), .si_in(si_in), .so_out(so_out), .so_oe_out(so_oe_out),
        .page512_in(page512_in), .ready_out(ready_out), .wr_ready_out(wr_ready_out),
        .arr_rd_out(arr_rd_out), .arr_rd_data_in(arr_rd_data_in), .arr_wr_out(arr_wr_out));

    sfb_host_model host (
        .sys_clk_in(sys_clk_in), .cs_n_out(cs_n_in), .sck_out(sck_in),
        .si_out(si_in), .so_in(so_out), .so_oe_in(so_oe_out));

    always #50 sys_clk_in = ~sys_clk_in;

    // Array contents as a fixed pattern of page and byte
    function automatic logic [7:0] pat(input logic [12:0] pg, input logic [9:0] by);
        return {pg[3:0], 4'h0} ^ by[7:0] ^ {6'h00, by[9:8]};
    endfunction
    assign arr_rd_data_in = pat(arr_rd_out.page_number_bits, arr_rd_out.byte_in_page_bits);

    always @(posedge sys_clk_in) begin
        cycles++;
        if (arr_wr_out.erase) begin
            er_seen = 1'b1;
            er_page = arr_wr_out.page;
        end
        if (arr_wr_out.en) begin
            wr_cnt++;
            wr_page = arr_wr_out.page;
            wr_idx = arr_wr_out.idx;
            if (arr_wr_out.idx == 10'h000) wr_first = arr_wr_out.data;
        end
        if (cycles == 40000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nd,
                      input logic [23:0] exp, input int n);
        host.cmd(op, a, nd, 0, n);
        for (int i = 0; i < n; i++) check(host.rbuf[i], exp[23-8*i -: 8]);
        check(host.oe_seen, 1'b1);
        check(so_oe_out, 1'b0);
    endtask

    task automatic t_buffers();
        page512_in = 1'b0;
        host.wbuf[0] = 8'ha5;
        host.wbuf[1] = 8'h3c;
        host.wbuf[2] = 8'h5a;
        host.cmd(8'h84, 24'h00020e, 0, 3, 0);
        host.wbuf[0] = 8'h11;
        host.wbuf[1] = 8'h22;
        host.cmd(8'h87, 24'hfffc00, 0, 2, 0);
        rd(8'hd4, 24'h00020e, 1, 24'ha53c5a, 3);
        rd(8'hd1, 24'hfffe0f, 1, 24'h3c0000, 1);
        rd(8'hd6, 24'h000000, 1, 24'h112200, 2);
        rd(8'hd3, 24'h000001, 1, 24'h220000, 1);
        page512_in = 1'b1;
        host.wbuf[0] = 8'h77;
        host.wbuf[1] = 8'h88;
        host.wbuf[2] = 8'h99;
        host.cmd(8'h84, 24'hfffffe, 0, 3, 0);
        rd(8'hd4, 24'hfffffe, 1, 24'h778899, 3);
    endtask

    task automatic t_reads();
        page512_in = 1'b0;
        rd(8'hd2, {1'b0, 13'h0abc, 10'h20f}, 4,
           {pat(13'h0abc, 10'h20f), pat(13'h0abc, 10'h000), 8'h00}, 2);
        page512_in = 1'b1;
        rd(8'hd2, {2'b00, 13'h0123, 9'h1ff}, 4,
           {pat(13'h0123, 10'h1ff), pat(13'h0123, 10'h000), 8'h00}, 2);
        page512_in = 1'b0;
        rd(8'he8, {1'b0, 13'h1fff, 10'h20f}, 4,
           {pat(13'h1fff, 10'h20f), pat(13'h0000, 10'h000), 8'h00}, 2);
        rd(8'hd6, 24'h000000, 1, 24'h112200, 2);
        rd(8'hd4, 24'h000000, 1, 24'h990000, 1);
    endtask

    task automatic prog(input logic [7:0] op, input logic [23:0] a, input logic ers,
                        input logic [12:0] pg, input int n, input logic [7:0] first);
        int t;
        er_seen = 1'b0;
        wr_cnt = 0;
        t = 0;
        host.cmd(op, a, 0, 0, 0);
        check(ready_out, 1'b0);
        // Array read while busy is ignored
        host.cmd(8'hd2, 24'h000000, 4, 0, 1);
        check(host.oe_seen, 1'b0);
        while (ready_out !== 1'b1 && t < 3000) begin
            @(negedge sys_clk_in);
            t++;
        end
        check(ready_out, 1'b1);
        check(er_seen, ers);
        if (ers) check(er_page, pg);
        check(wr_cnt, n);
        check(wr_page, pg);
        check(wr_idx, n - 1);
        check(wr_first, first);
    endtask

    task automatic t_programs();
        page512_in = 1'b1;
        prog(8'h83, {2'b11, 13'h1555, 9'h1ff}, 1'b1, 13'h1555, 512, 8'h99);
        page512_in = 1'b0;
        // 89H programs without erase; no erase pulse expected
        prog(8'h89, {1'b1, 13'h0f0f, 10'h3ff}, 1'b0, 13'h0f0f, 528, 8'h11);
    endtask

    task automatic final_report();
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk_in = 1'b0;
        rst_n_in = 1'b0;
        page512_in = 1'b0;
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        wr_cnt = 0;
        er_seen = 1'b0;
        er_page = 13'h0000;
        wr_first = 8'h00;
        repeat (5) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        repeat (8) @(negedge sys_clk_in);
        check({ready_out, so_oe_out, wr_ready_out, arr_wr_out.erase, arr_wr_out.en, arr_rd_out},
              28'ha000000);
        t_buffers();
        t_reads();
        t_programs();
        final_report();
    end
endmodule // tb_top
`default_nettype wire
